// ==== design/sdc_cfg.svh ====
// Constants of the SDRAM command, timing and low-power control block.
// Included by the package and the controller; it holds definitions only.
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// Register byte offsets within the register window.
`define SDC_OFS_MODE      8'h00
`define SDC_OFS_REFRESH   8'h04
`define SDC_OFS_GEOM      8'h08
`define SDC_OFS_LOWPWR    8'h10
`define SDC_OFS_STATUS    8'h20

// Address bit that selects the memory window instead of the registers.
`define SDC_MEM_WIN_BIT   12

// Field positions.
`define SDC_MR_MODE       2:0
`define SDC_TR_COUNT      11:0
`define SDC_CR_COLS       1:0
`define SDC_CR_ROWS       3:2
`define SDC_CR_BANKS      4
`define SDC_CR_CAS        6:5
`define SDC_CR_DBW        7
`define SDC_CR_TWR        11:8
`define SDC_CR_TRC        15:12
`define SDC_CR_TRP        19:16
`define SDC_CR_ROW_TO_COLUMN_CYCLES       23:20
`define SDC_CR_ACTIVE_TO_PRECHARGE_CYCLES       27:24
`define SDC_CR_SELFREFRESH_EXIT_CYCLES       31:28
`define SDC_LPR_LOW_POWER_CONFIG      1:0
`define SDC_LPR_PARTIAL_ARRAY_REFRESH      6:4
`define SDC_LPR_TEMP_COMP_REFRESH      9:8
`define SDC_LPR_DS        11:10
`define SDC_LPR_TMO       13:12
`define SDC_LPR_WMASK     32'h00003F73
`define SDC_SR_REFERR     0

// Reset values.
`define SDC_MR_RESET      3'h0
`define SDC_TR_RESET      12'h000
`define SDC_CR_RESET      32'h852372C0
`define SDC_LPR_RESET     32'h00000000

// Idle time before low-power entry, in clock cycles.
`define SDC_TMO_NONE      8'h00
`define SDC_TMO_64        8'h40
`define SDC_TMO_128       8'h80

`endif

// ==== design/sdc_pkg.sv ====
// Types shared by the SDRAM control block and its bench.
// Assumes the constants header sits beside it in design/.
`include "sdc_cfg.svh"

package sdc_pkg;

  // Command presented to the memory for one cycle.
  typedef enum logic [3:0] {
    SDC_NOP, SDC_ACT, SDC_READ, SDC_WRITE, SDC_PRE_ALL, SDC_LMR, SDC_ELMR,
    SDC_REF, SDC_SREF, SDC_PDOWN, SDC_DPD
  } sdc_cmd_t;

  // Command-mode codes as software writes them.
  typedef enum logic [2:0] {
    SDC_CM_NORMAL = 3'h0, SDC_CM_NOP = 3'h1, SDC_CM_PALL = 3'h2, SDC_CM_LMR = 3'h3,
    SDC_CM_AREF = 3'h4, SDC_CM_ELMR = 3'h5, SDC_CM_DEEP = 3'h6, SDC_CM_RSVD = 3'h7
  } sdc_cmode_t;

  // Low-power configuration codes.
  typedef enum logic [1:0] {
    SDC_LP_OFF = 2'h0, SDC_LP_SELF = 2'h1, SDC_LP_PDOWN = 2'h2, SDC_LP_DEEP = 2'h3
  } sdc_lp_t;

endpackage : sdc_pkg

// ==== design/sdc_ctrl.sv ====
// SDRAM command sequencing, refresh timer, timing and low-power control.
// Assumes one AHB-Lite master; accesses to the memory window start SDRAM work.
// Operation
// R1 - Mode zero decodes normally; new mode needs write.
// R2 - Modes 1,2,3 issue NOP, precharge-all, load-mode.
// R3 - Mode 4 refreshes; software precharges first.
// R4 - Mode 5 issues extended load-mode to addressed bank.
// R5 - Mode 6 enters deep power-down.
// R6 - Twelve-bit count reloads timer; expiry starts refresh.
// R7 - No refresh until count is written.
// R8 - Column field selects 8..11 bits, reset 8.
// R9 - Row field selects 11..13 bits, reset 11.
// R10 - Bank bit selects two or four banks.
// R11 - Latency field gives 1..3 cycles, reset 2.
// R12 - Width bit selects 32 or 16, reset 16.
// R13 - Write recovery 0..15 cycles, reset 2.
// R14 - Refresh to activate spacing, reset 7.
// R15 - Precharge delay reset 3; activate-to-column reset 2.
// R16 - Activate to precharge minimum, reset 5.
// R17 - Clock-enable high to activate wait, reset 8.
// R18 - Code 00 issues no low-power commands.
// R19 - Self-refresh stops clock; exits on access, re-enters.
// R20 - Power-down after each access; leaves on access.
// R21 - Code 11 issues deep power-down.
// R22 - Partial-array and temperature bits sent at initialization.
// R23 - Timeout delays low-power entry 0/64/128 cycles.
// R24 - Missed refresh flags error; status read acknowledges.
// R25 - Access stalls while refresh and row-cycle finish.
`timescale 1ns/1ns
`include "sdc_cfg.svh"

module sdc_ctrl (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               ce,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  output sdc_pkg::sdc_cmd_t       mem_cmd,
  output logic [1:0]              mem_bank,
  output logic [12:0]             mem_mode_word,
  output logic                    mem_clock_enable,
  output logic                    mem_clock_out_en,
  output logic                    refresh_error_flag
);
  import sdc_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_RCD, ST_RECOV, ST_WAIT, ST_SELF, ST_PDOWN, ST_DEEP
  } sdc_state_t;

  sdc_state_t  state;
  logic [2:0]  cmd_mode_sel;
  sdc_cmode_t  active_mode;
  logic [11:0] ref_count;
  logic        ref_armed;
  logic [11:0] ref_timer;
  logic        ref_pend;
  logic [31:0] geom;
  logic [31:0] lpr;
  logic        wr_pend;
  logic        rd_pend;
  logic [7:0]  ph_addr;
  logic        mem_pend;
  logic        mem_wr;
  logic        serving_acc;
  logic [3:0]  wait_cnt;
  logic [3:0]  ras_cnt;
  logic [3:0]  self_cnt;
  logic [7:0]  idle_cnt;

  // Address-phase decode.
  wire         addr_ok    = hsel & hready & htrans[1];
  wire         in_window  = haddr[`SDC_MEM_WIN_BIT];
  wire         req_reg_wr = addr_ok & hwrite & ~in_window;
  wire         req_reg_rd = addr_ok & ~hwrite & ~in_window;
  wire         req_mem    = addr_ok & in_window;
  wire         wr_mode    = wr_pend & (ph_addr == `SDC_OFS_MODE);
  wire         wr_refresh = wr_pend & (ph_addr == `SDC_OFS_REFRESH);
  wire         wr_geom    = wr_pend & (ph_addr == `SDC_OFS_GEOM);
  wire         wr_lowpwr  = wr_pend & (ph_addr == `SDC_OFS_LOWPWR);
  wire         rd_status  = rd_pend & (ph_addr == `SDC_OFS_STATUS);

  wire [31:0]  rd_val =
    (ph_addr == `SDC_OFS_MODE)    ? {29'h0, cmd_mode_sel} :
    (ph_addr == `SDC_OFS_REFRESH) ? {20'h0, ref_count} :
    (ph_addr == `SDC_OFS_GEOM)    ? geom :
    (ph_addr == `SDC_OFS_LOWPWR)  ? lpr :
    (ph_addr == `SDC_OFS_STATUS)  ? {31'h0, refresh_error_flag} : 32'h0;

  // Timing fields.
  wire [3:0]   t_wr   = geom[`SDC_CR_TWR];
  wire [3:0]   t_rc   = geom[`SDC_CR_TRC];
  wire [3:0]   t_rp   = geom[`SDC_CR_TRP];
  wire [3:0]   t_rcd  = geom[`SDC_CR_ROW_TO_COLUMN_CYCLES];
  wire [3:0]   t_ras  = geom[`SDC_CR_ACTIVE_TO_PRECHARGE_CYCLES];
  wire [3:0]   t_xsr  = geom[`SDC_CR_SELFREFRESH_EXIT_CYCLES];
  wire [1:0]   cas    = geom[`SDC_CR_CAS];
  wire sdc_lp_t low_power_config  = sdc_lp_t'(lpr[`SDC_LPR_LOW_POWER_CONFIG]);
  wire [1:0]   tmo    = lpr[`SDC_LPR_TMO];

  // Refresh timer.
  wire         ref_tick   = ref_armed & (ref_timer == 12'h000);
  wire         ref_sleeps = (state == ST_SELF) | (state == ST_DEEP);
  wire         ref_take   = (state == ST_IDLE) & ref_pend;
  wire         err_set    = ref_tick & ref_pend & ~ref_take;

  // Low-power entry timing.
  wire [7:0]   tmo_cycles = (tmo == 2'h0) ? `SDC_TMO_NONE :
                            (tmo == 2'h1) ? `SDC_TMO_64 : `SDC_TMO_128;
  wire         lp_due     = (idle_cnt >= tmo_cycles) & (low_power_config != SDC_LP_OFF);
  wire         wait_done  = (wait_cnt == 4'h0);
  wire         acc_done   = (state == ST_WAIT) & wait_done & serving_acc;
  wire         deep_stays = (active_mode == SDC_CM_DEEP) | (low_power_config == SDC_LP_DEEP);

  // Bus side: register writes land in the data phase, reads take one wait
  // state so that a write just before a read is already visible.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      ph_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
    end else if (ce) begin
      wr_pend <= req_reg_wr;
      rd_pend <= req_reg_rd;
      if (req_reg_wr | req_reg_rd)
        ph_addr <= haddr[7:0];
      if (rd_pend)
        hrdata <= rd_val;
      if (req_reg_rd | req_mem)
        hreadyout <= 1'b0;
      else if (rd_pend | acc_done)
        hreadyout <= 1'b1; // R25
      else if ((state == ST_DEEP) & mem_pend & deep_stays)
        hreadyout <= 1'b1;
    end
  end

  // Configuration registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_mode_sel <= `SDC_MR_RESET;
      active_mode  <= SDC_CM_NORMAL;
      ref_count    <= `SDC_TR_RESET;
      geom         <= `SDC_CR_RESET; // R8 R9 R10 R11 R12 R13 R14 R15 R16 R17
      lpr          <= `SDC_LPR_RESET;
    end else if (ce) begin
      if (wr_mode)
        cmd_mode_sel <= hwdata[`SDC_MR_MODE];
      if (req_mem & hwrite)
        active_mode <= sdc_cmode_t'(cmd_mode_sel); // R1
      if (wr_refresh)
        ref_count <= hwdata[`SDC_TR_COUNT];
      if (wr_geom)
        geom <= hwdata;
      if (wr_lowpwr)
        lpr <= hwdata & `SDC_LPR_WMASK;
    end
  end

  // Refresh timer and missed-refresh flag; a new error beats the read clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_armed          <= 1'b0;
      ref_timer          <= 12'h000;
      ref_pend           <= 1'b0;
      refresh_error_flag <= 1'b0;
    end else if (ce) begin
      if (wr_refresh) begin
        ref_armed <= 1'b1; // R7
        ref_timer <= hwdata[`SDC_TR_COUNT];
      end else if (ref_tick)
        ref_timer <= ref_count; // R6
      else if (ref_armed)
        ref_timer <= ref_timer - 12'h001;
      if (ref_tick & ~ref_sleeps)
        ref_pend <= 1'b1; // R6
      else if (ref_take)
        ref_pend <= 1'b0;
      if (err_set)
        refresh_error_flag <= 1'b1; // R24
      else if (rd_status)
        refresh_error_flag <= 1'b0; // R24
    end
  end

  // Idle and activate-to-precharge counters.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt <= 8'h00;
      ras_cnt  <= 4'h0;
    end else if (ce) begin
      if ((state != ST_IDLE) | mem_pend | req_mem)
        idle_cnt <= 8'h00; // R23
      else if (idle_cnt != `SDC_TMO_128)
        idle_cnt <= idle_cnt + 8'h01;
      if ((state == ST_IDLE) & mem_pend & ~ref_pend & (active_mode == SDC_CM_NORMAL))
        ras_cnt <= t_ras; // R16
      else if (ras_cnt != 4'h0)
        ras_cnt <= ras_cnt - 4'h1;
    end
  end

  // Memory sequencer. Refresh goes ahead of a waiting access, which keeps
  // the bus stalled until the row-cycle wait has run out.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state            <= ST_IDLE;
      mem_cmd          <= SDC_NOP;
      mem_bank         <= 2'h0;
      mem_mode_word    <= 13'h0000;
      mem_clock_enable <= 1'b1;
      mem_clock_out_en <= 1'b1;
      mem_pend         <= 1'b0;
      mem_wr           <= 1'b0;
      serving_acc      <= 1'b0;
      wait_cnt         <= 4'h0;
      self_cnt         <= 4'h0;
    end else if (ce) begin
      mem_cmd <= SDC_NOP;
      if (req_mem) begin
        mem_pend <= 1'b1;
        mem_wr   <= hwrite;
        mem_bank <= haddr[3:2]; // R4
      end
      case (state)
        ST_IDLE: begin
          if (ref_pend) begin
            mem_cmd     <= SDC_REF; // R6
            wait_cnt    <= t_rc; // R14 R25
            serving_acc <= 1'b0;
            state       <= ST_WAIT;
          end else if (mem_pend) begin
            mem_pend    <= 1'b0;
            serving_acc <= 1'b1;
            state       <= ST_WAIT;
            wait_cnt    <= 4'h0;
            case (active_mode)
              SDC_CM_NORMAL: begin
                mem_cmd  <= SDC_ACT; // R1
                wait_cnt <= t_rcd; // R15
                state    <= ST_RCD;
              end
              SDC_CM_PALL: begin
                mem_cmd  <= SDC_PRE_ALL; // R2
                wait_cnt <= t_rp; // R15
              end
              SDC_CM_LMR: begin
                mem_cmd       <= SDC_LMR; // R2
                mem_mode_word <= {6'h00, 1'b0, cas, 4'h0}; // R11
              end
              SDC_CM_AREF: begin
                mem_cmd  <= SDC_REF; // R3
                wait_cnt <= t_rc; // R14
              end
              SDC_CM_ELMR: begin
                mem_cmd       <= SDC_ELMR; // R4
                mem_mode_word <= {6'h00, lpr[`SDC_LPR_DS], lpr[`SDC_LPR_TEMP_COMP_REFRESH],
                                  lpr[`SDC_LPR_PARTIAL_ARRAY_REFRESH]}; // R22
              end
              SDC_CM_DEEP: begin
                mem_cmd          <= SDC_DPD; // R5
                mem_clock_enable <= 1'b0;
                state            <= ST_DEEP;
                serving_acc      <= 1'b0;
                // Left set so that the deep state completes this access next cycle.
                mem_pend         <= 1'b1;
              end
              default: mem_cmd <= SDC_NOP; // R2
            endcase
          end else if (lp_due) begin
            mem_clock_enable <= 1'b0; // R18
            case (low_power_config)
              SDC_LP_SELF: begin
                mem_cmd          <= SDC_SREF; // R19
                mem_clock_out_en <= 1'b0;
                self_cnt         <= t_ras;
                state            <= ST_SELF;
              end
              SDC_LP_PDOWN: begin
                mem_cmd <= SDC_PDOWN; // R20
                state   <= ST_PDOWN;
              end
              default: begin
                mem_cmd <= SDC_DPD; // R21
                state   <= ST_DEEP;
              end
            endcase
          end
        end
        ST_RCD: begin
          if (wait_done) begin
            mem_cmd  <= mem_wr ? SDC_WRITE : SDC_READ;
            wait_cnt <= mem_wr ? t_wr : {2'h0, cas}; // R13 R11
            state    <= ST_RECOV;
          end else
            wait_cnt <= wait_cnt - 4'h1;
        end
        ST_RECOV: begin
          if (wait_done & (ras_cnt == 4'h0)) begin
            mem_cmd  <= SDC_PRE_ALL; // R16
            wait_cnt <= t_rp; // R15
            state    <= ST_WAIT;
          end else if (!wait_done)
            wait_cnt <= wait_cnt - 4'h1;
        end
        ST_WAIT: begin
          if (wait_done) begin
            state       <= ST_IDLE;
            serving_acc <= 1'b0;
          end else
            wait_cnt <= wait_cnt - 4'h1;
        end
        ST_SELF: begin
          // The device must stay in self-refresh for the activate-to-precharge time.
          if (self_cnt != 4'h0)
            self_cnt <= self_cnt - 4'h1;
          else if (mem_pend | (low_power_config != SDC_LP_SELF)) begin
            mem_clock_enable <= 1'b1; // R19
            mem_clock_out_en <= 1'b1;
            wait_cnt         <= t_xsr; // R17
            state            <= ST_WAIT;
          end
        end
        ST_PDOWN: begin
          if (mem_pend | ref_pend | (low_power_config != SDC_LP_PDOWN)) begin
            mem_clock_enable <= 1'b1; // R20
            state            <= ST_IDLE;
          end
        end
        ST_DEEP: begin
          // Contents are gone; accesses only complete until the mode is left.
          if (mem_pend & deep_stays)
            mem_pend <= 1'b0;
          else if (mem_pend) begin
            mem_clock_enable <= 1'b1;
            mem_clock_out_en <= 1'b1;
            wait_cnt         <= t_xsr; // R17
            state            <= ST_WAIT;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule : sdc_ctrl

// ==== testbench/sdc_ctrl_monitor.sv ====
// Port checker for the SDRAM command, timing and low-power block.
// Assumes one clock domain and that the clock enable stays high in the bench.
`timescale 1ns/1ns
module sdc_ctrl_chk
  import sdc_pkg::*;
(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              ce,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [31:0]       hrdata,
  input wire sdc_pkg::sdc_cmd_t mem_cmd,
  input wire logic [1:0]        mem_bank,
  input wire logic [12:0]       mem_mode_word,
  input wire logic              mem_clock_enable,
  input wire logic              mem_clock_out_en,
  input wire logic              refresh_error_flag
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  wire logic take    = hsel && hready && htrans[1] && ce;
  wire logic reg_rd  = take && !hwrite && !haddr[12];
  wire logic stat_rd = reg_rd && haddr[7:0] == 8'h20;
  wire logic mem_acc = take && haddr[12];

  // A register read costs exactly one wait state, never more.
  sequence seq_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence seq_clock_stopped;
    !mem_clock_enable && !mem_clock_out_en;
  endsequence

  chk_resp_okay: assert property (!hresp)
    else $error("slave gave an error response");
  chk_read_wait: assert property (reg_rd |=> seq_one_wait)
    else $error("register read wait state wrong");
  chk_write_nowait: assert property (take && hwrite && !haddr[12] |=> hreadyout)
    else $error("register write stalled");
  chk_mem_stall: assert property (mem_acc |=> !hreadyout)
    else $error("memory access not stalled");
  chk_wait_bound: assert property ($fell(hreadyout) |-> ##[1:300] hreadyout)
    else $error("memory access never completed");
  chk_sref_entry: assert property (mem_cmd == SDC_SREF |-> ##[0:2] seq_clock_stopped)
    else $error("self-refresh left clock running");
  chk_pdown_entry: assert property (mem_cmd == SDC_PDOWN |-> ##[0:2] !mem_clock_enable)
    else $error("power-down left clock enable high");
  chk_lmr_word: assert property (mem_cmd == SDC_LMR |-> (mem_mode_word & 13'h1FCF) == 13'h0000)
    else $error("mode word carries stray bits");
  chk_elmr_word: assert property (mem_cmd == SDC_ELMR |-> mem_mode_word[12:7] == 6'h00)
    else $error("extended mode word carries stray bits");
  chk_exit_gap: assert property ($rose(mem_clock_enable) |-> mem_cmd != SDC_ACT)
    else $error("activate together with clock enable rise");
  chk_err_sticky: assert property (refresh_error_flag && !stat_rd && !$past(stat_rd)
      && !$past(stat_rd, 2) |=> refresh_error_flag)
    else $error("refresh error dropped without status read");
  chk_ref_stall: assert property (mem_cmd == SDC_REF && !hreadyout |=> !hreadyout)
    else $error("access released during refresh");
endmodule : sdc_ctrl_chk

bind sdc_ctrl sdc_ctrl_chk sdc_ctrl_chk_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .mem_cmd(mem_cmd), .mem_bank(mem_bank), .mem_mode_word(mem_mode_word),
  .mem_clock_enable(mem_clock_enable), .mem_clock_out_en(mem_clock_out_en),
  .refresh_error_flag(refresh_error_flag));

// ==== testbench/sdc_mem_model.sv ====
// Behavioural SDRAM device that records the commands it receives.
// Assumes commands are sampled on the controller clock edge.
`timescale 1ns/1ns
module sdc_mem_model
  import sdc_pkg::*;
(
  input wire logic              hclk,
  input wire sdc_pkg::sdc_cmd_t mem_cmd,
  input wire logic [1:0]        mem_bank,
  input wire logic [12:0]       mem_mode_word,
  input wire logic              mem_clock_enable
);
  int          cnt [16] = '{default: 0};
  int          total    = 0;
  int          viol     = 0;
  sdc_cmd_t    last_cmd = SDC_NOP;
  logic [12:0] mode_word, ext_word;
  logic [1:0]  ext_bank;
  logic        open_row = 1'b0;

  always @(posedge hclk) begin
    if (mem_cmd !== SDC_NOP) begin
      cnt[mem_cmd]++;
      total++;
      last_cmd = mem_cmd;
    end
    if (mem_cmd == SDC_ACT) open_row = 1'b1;
    if (mem_cmd == SDC_PRE_ALL) open_row = 1'b0;
    // A real part corrupts rows refreshed while one is open, so count it as a fault.
    if (mem_cmd == SDC_REF && open_row) viol++;
    if (mem_cmd == SDC_LMR) mode_word = mem_mode_word;
    if (mem_cmd == SDC_ELMR) begin
      ext_word = mem_mode_word;
      ext_bank = mem_bank;
    end
    if (mem_cmd inside {SDC_ACT, SDC_READ, SDC_WRITE} && !mem_clock_enable) viol++;
  end
endmodule : sdc_mem_model

// ==== testbench/sdc_ctrl_test.sv ====
// Self-checking bench for the SDRAM command, timing and low-power block.
// Assumes the checker is bound in and the memory model watches the command port.
`timescale 1ns/1ns
module sdc_ctrl_test;
  import sdc_pkg::*;
  logic        hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp;
  logic        mem_clock_enable, mem_clock_out_en, refresh_error_flag;
  logic [1:0]  htrans, mem_bank;
  logic [12:0] mem_mode_word;
  logic [31:0] haddr, hwdata, hrdata, rd;
  sdc_cmd_t    mem_cmd;
  wire logic   hready = hreadyout;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          t;
  localparam logic [31:0] GEOM_RST = {4'h8, 4'h5, 4'h2, 4'h3, 4'h7, 4'h2, 8'hC0};
  localparam logic [2:0]  MD [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3, 3'h5, 3'h6};
  localparam sdc_cmd_t    EX [7] = '{SDC_PRE_ALL, SDC_NOP, SDC_PRE_ALL, SDC_REF,
                                     SDC_LMR, SDC_ELMR, SDC_DPD};
  localparam int          DL [7] = '{3, 0, 1, 1, 1, 1, 1};

  sdc_ctrl sdc_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_cmd(mem_cmd),
    .mem_bank(mem_bank), .mem_mode_word(mem_mode_word), .mem_clock_enable(mem_clock_enable),
    .mem_clock_out_en(mem_clock_out_en), .refresh_error_flag(refresh_error_flag));
  sdc_mem_model sdc_mem_model_inst (.hclk(hclk), .mem_cmd(mem_cmd), .mem_bank(mem_bank),
    .mem_mode_word(mem_mode_word), .mem_clock_enable(mem_clock_enable));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task conclude;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 400);
    if (n >= 400) begin
      chk(1'b0, "bus hang");
      conclude();
    end
  endtask : wait_ready

  task xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : xfer

  task rdc(input logic [31:0] a, input logic [31:0] exp, input string msg);
    xfer(a, 1'b0, 32'h00000000);
    chk(rd === exp, msg);
  endtask : rdc

  task reset_values;
    rdc(32'h00, 32'h00000000, "mode reset");
    rdc(32'h04, 32'h00000000, "refresh reset");
    rdc(32'h08, GEOM_RST, "geometry reset");
    rdc(32'h10, 32'h00000000, "low power reset");
    rdc(32'h0C, 32'h00000000, "unmapped read");
  endtask : reset_values

  task reg_access;
    xfer(32'h08, 1'b1, 32'h12345AB6);
    rdc(32'h08, 32'h12345AB6, "geometry write");
    xfer(32'h08, 1'b1, GEOM_RST);
    xfer(32'h10, 1'b1, 32'hFFFFFFFC);
    rdc(32'h10, 32'h00003F70, "low power mask");
    xfer(32'h10, 1'b1, 32'h00000650);
  endtask : reg_access

  // Each mode is armed by a register write and fired by a memory write at bank one.
  task cmd_modes;
    for (int i = 0; i < 7; i++) begin
      xfer(32'h00, 1'b1, {29'h0, MD[i]});
      if (i == 3) begin
        xfer(32'h1004, 1'b0, 32'h0);
        chk(sdc_mem_model_inst.last_cmd === SDC_PRE_ALL, "mode armed by read");
      end
      t = sdc_mem_model_inst.total;
      xfer(32'h1004, 1'b1, 32'h0);
      chk(sdc_mem_model_inst.total - t == DL[i], "command count");
      if (DL[i] > 0) chk(sdc_mem_model_inst.last_cmd === EX[i], "command kind");
    end
    chk(sdc_mem_model_inst.mode_word === 13'h0020, "load mode word");
    chk(sdc_mem_model_inst.ext_word === 13'h0035, "extended word");
    chk(sdc_mem_model_inst.ext_bank === 2'h1, "extended bank");
    xfer(32'h00, 1'b1, 32'h0);
    xfer(32'h1000, 1'b1, 32'h0);
  endtask : cmd_modes

  task refresh_timer;
    t = sdc_mem_model_inst.cnt[SDC_REF];
    repeat (300) @(posedge hclk);
    chk(sdc_mem_model_inst.cnt[SDC_REF] == t, "refresh before count");
    xfer(32'h04, 1'b1, 32'h00000020);
    t = sdc_mem_model_inst.cnt[SDC_REF];
    repeat (330) @(posedge hclk);
    t = sdc_mem_model_inst.cnt[SDC_REF] - t;
    chk(t >= 9 && t <= 11, "refresh rate");
    chk(refresh_error_flag === 1'b0, "false refresh error");
    xfer(32'h04, 1'b1, 32'h00000001);
    repeat (40) @(posedge hclk);
    chk(refresh_error_flag === 1'b1, "missed refresh");
    xfer(32'h04, 1'b1, 32'h00000FFF);
    repeat (20) @(posedge hclk);
    rdc(32'h20, 32'h00000001, "error status");
    rdc(32'h20, 32'h00000000, "error acknowledge");
  endtask : refresh_timer

  task low_power;
    xfer(32'h10, 1'b1, 32'h00000652);
    xfer(32'h1000, 1'b1, 32'h0);
    repeat (10) @(posedge hclk);
    chk(mem_clock_enable === 1'b0, "power-down entry");
    xfer(32'h10, 1'b1, 32'h00001651);
    xfer(32'h1000, 1'b1, 32'h0);
    repeat (40) @(posedge hclk);
    chk(mem_clock_enable === 1'b1, "early low-power entry");
    repeat (60) @(posedge hclk);
    chk(mem_clock_enable === 1'b0 && mem_clock_out_en === 1'b0, "self-refresh entry");
    xfer(32'h1000, 1'b1, 32'h0);
    chk(mem_clock_enable === 1'b1, "self-refresh exit");
    xfer(32'h10, 1'b1, 32'h00000650);
    xfer(32'h1000, 1'b1, 32'h0);
    t = sdc_mem_model_inst.cnt[SDC_SREF] + sdc_mem_model_inst.cnt[SDC_PDOWN];
    repeat (200) @(posedge hclk);
    chk(sdc_mem_model_inst.cnt[SDC_SREF] + sdc_mem_model_inst.cnt[SDC_PDOWN] == t
        && mem_clock_enable === 1'b1, "low power while off");
    xfer(32'h10, 1'b1, 32'h00000653);
    repeat (20) @(posedge hclk);
    chk(sdc_mem_model_inst.last_cmd === SDC_DPD, "deep power-down");
  endtask : low_power

  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    reset_values();
    reg_access();
    cmd_modes();
    refresh_timer();
    low_power();
    chk(sdc_mem_model_inst.viol == 0, "illegal memory command order");
    conclude();
  end
endmodule : sdc_ctrl_test
